// [include/ccs_pkg.sv]
// Shared constants for the clocked serial channel start and status block
package ccs_pkg;

   // Bus geometry
   localparam int unsigned AXI_ADDR_W      = 8;
   localparam int unsigned AXI_DATA_W      = 32;

   // Register byte offsets
   localparam logic [7:0]  OFF_IRQ_FLAG    = 8'h00;
   localparam logic [7:0]  OFF_IRQ_MASK    = 8'h04;
   localparam logic [7:0]  OFF_START_TRIG  = 8'h08;
   localparam logic [7:0]  OFF_STATUS      = 8'h0C;
   localparam logic [7:0]  OFF_DATA        = 8'h10;
   localparam logic [7:0]  OFF_ALIAS       = 8'h14;
   localparam logic [7:0]  OFF_ENABLE      = 8'h18;
   localparam logic [7:0]  OFF_ERR_CLEAR   = 8'h1C;

   // Field positions
   localparam int unsigned XFER_END_BIT    = 5;
   localparam int unsigned START_BIT       = 0;
   localparam int unsigned ENABLE_BIT      = 0;
   localparam int unsigned IN_PROGRESS_BIT = 6;
   localparam int unsigned BUF_FULL_BIT    = 5;
   localparam int unsigned FRAMING_BIT     = 2;
   localparam int unsigned PARITY_BIT      = 1;
   localparam int unsigned OVERRUN_BIT     = 0;
   localparam int unsigned DIV_LSB         = 9;
   localparam int unsigned DIV_W           = 7;
   localparam int unsigned BYTE_W          = 8;

   // Reset values
   localparam logic        FLAG_RESET      = 1'b0;
   localparam logic        MASK_RESET      = 1'b1;
   localparam logic [6:0]  DIV_RESET       = 7'h00;
   localparam logic [7:0]  BYTE_RESET      = 8'h00;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   // Timing
   localparam int unsigned CORE_CLK_HZ     = 10_000_000;
   localparam int unsigned SYNC_STAGES     = 2;

endpackage

// [design/ccs_sync.sv]
// Two-stage synchroniser for inputs from outside the core clock domain
`timescale 1ns/1ns
module ccs_sync
   import ccs_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Refuse a zero-width synchroniser
   if (WIDTH < 1) begin : g_chk
      $error("ccs_sync WIDTH must be at least 1");
   end

   // First stage is read only by the second stage
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule // ccs_sync

// [design/ccs_shifter.sv]
// Byte shift engine with divided serial clock, MSB first
`timescale 1ns/1ns
module ccs_shifter
   import ccs_pkg::*;
#(
   parameter int unsigned XFER_BITS = 8
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Control
   input  wire logic             start,
   input  wire logic [7:0]       tx_byte,
   input  wire logic [6:0]       div_sel,
   output      logic             busy,
   output      logic             done,
   output      logic [7:0]       rx_byte,
   // Serial lines, data in already synchronised
   input  wire logic             si_sync,
   output      logic             sck_out,
   output      logic             so_out
);

   logic [7:0] half_cnt_ff;
   logic [7:0] half_len_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shreg_ff;
   logic [7:0] rx_ff;
   logic       busy_ff;
   logic       done_ff;
   logic       sck_ff;
   logic       so_ff;
   logic       half_end;
   logic       last_bit;

   // Refuse lengths the byte path cannot carry
   if (XFER_BITS < 1 || XFER_BITS > 8) begin : g_chk
      $error("ccs_shifter XFER_BITS must be 1 to 8");
   end

   // Half period of the serial clock is field plus one core cycles
   assign half_end = busy_ff && (half_cnt_ff == half_len_ff);
   assign last_bit = (bit_cnt_ff == 4'(XFER_BITS - 1));

   // Low phase drives data, rising edge samples, high phase advances
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         half_cnt_ff <= 8'h00;
         half_len_ff <= 8'h00;
         bit_cnt_ff  <= 4'h0;
         shreg_ff    <= 8'h00;
         rx_ff       <= 8'h00;
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
         sck_ff      <= 1'b1;
         so_ff       <= 1'b1;
      end else begin
         done_ff <= 1'b0;
         if (start && !busy_ff) begin
            half_len_ff <= {1'b0, div_sel};
            half_cnt_ff <= 8'h00;
            bit_cnt_ff  <= 4'h0;
            shreg_ff    <= tx_byte << (8 - XFER_BITS);
            so_ff       <= tx_byte[XFER_BITS-1];
            sck_ff      <= 1'b0;
            busy_ff     <= 1'b1;
         end else if (half_end) begin
            half_cnt_ff <= 8'h00;
            if (!sck_ff) begin
               sck_ff   <= 1'b1;
               shreg_ff <= {shreg_ff[6:0], si_sync};
            end else if (last_bit) begin
               busy_ff  <= 1'b0;
               done_ff  <= 1'b1;
               rx_ff    <= shreg_ff;
            end else begin
               sck_ff     <= 1'b0;
               so_ff      <= shreg_ff[7];
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
         end else if (busy_ff) begin
            half_cnt_ff <= half_cnt_ff + 8'h01;
         end
      end
   end

   assign busy    = busy_ff;
   assign done    = done_ff;
   assign rx_byte = rx_ff;
   assign sck_out = sck_ff;
   assign so_out  = so_ff;

endmodule // ccs_shifter

// [design/ccs_top.sv]
// Clocked serial channel: start trigger, status, data register, interrupt, AXI4-Lite slave
//
// Behaviour
// RL1 - The transfer-end request flag sits at bit 5 of the interrupt flag byte, 1 meaning pending.
// RL2 - Bit 5 of the interrupt mask byte masks the transfer-end interrupt when 1.
// RL3 - Software clears the request flag and then unmasks before servicing transfers.
// RL4 - Writing 1 to bit 0 of the start trigger sets the channel enable and waits; 0 does nothing.
// RL5 - The start trigger register always reads as zero.
// RL6 - Status bit 6 reads 1 while a communication is in progress, else 0.
// RL7 - Status holds buffer-full at bit 5 and framing, parity, overrun at bits 2, 1, 0; rest zero.
// RL8 - Writing the low eight bits of the data register starts shifting that byte out.
// RL9 - The low byte of the data register is also reachable as a separate 8-bit alias.
// RL10 - Data bits 15 to 9 set the serial clock to the core clock over twice the field plus one.
// RL11 - At transfer end the request flag sets and in-progress clears unless another byte waits.
// RL12 - Software waits on in-progress or the interrupt before writing the next byte.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
module ccs_top
   import ccs_pkg::*;
#(
   parameter int unsigned XFER_BITS = 8
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // AXI4-Lite write address
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   // AXI4-Lite read data
   output      logic [AXI_DATA_W-1:0] s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Interrupt
   output      logic                  irq,
   // Serial link
   output      logic                  sck_out,
   output      logic                  so_out,
   input  wire logic                  si_in
);

   // Word-aligned address match, shared by the write and read decoders
   function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] addr,
                                     input logic [7:0] off);
      addr_hit = (addr[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2]);
   endfunction

   // Bus state
   logic [AXI_ADDR_W-1:0] aw_addr_ff;
   logic                  aw_held_ff;
   logic [AXI_DATA_W-1:0] w_data_ff;
   logic [3:0]            w_strb_ff;
   logic                  w_held_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  rvalid_ff;
   logic [1:0]            rresp_ff;
   logic [AXI_DATA_W-1:0] rdata_ff;

   // Channel state
   logic                  flag_ff;
   logic                  mask_ff;
   logic                  enable_ff;
   logic                  buf_full_ff;
   logic                  overrun_ff;
   logic [DIV_W-1:0]      div_ff;
   logic [BYTE_W-1:0]     tx_ff;
   logic [BYTE_W-1:0]     rx_ff;
   logic                  irq_ff;

   // Next values
   logic                  nxt_flag;
   logic                  nxt_buf_full;
   logic                  nxt_overrun;

   // Shift engine wires
   logic                  si_sync;
   logic                  sh_busy;
   logic                  sh_done;
   logic [BYTE_W-1:0]     sh_rx;
   logic                  sh_start;

   // Write decode
   logic                  do_write;
   logic                  lane0;
   logic                  lane1;
   logic                  wr_flag;
   logic                  wr_mask;
   logic                  wr_trig;
   logic                  wr_data;
   logic                  wr_alias;
   logic                  wr_errclr;
   logic                  wr_mapped;
   logic                  load_byte;

   // Read decode
   logic                  rd_take;
   logic                  rd_mapped;
   logic [AXI_DATA_W-1:0] rd_mux;
   logic [15:0]           status_word;
   logic [15:0]           data_word;

   // Handshakes: one write and one read at a time
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;
   assign rd_take       = s_axi_arvalid && !rvalid_ff;

   // Write address and data are taken in either order
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   // Write response, error for an unmapped word
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Register select for a committed write
   assign lane0     = w_strb_ff[0];
   assign lane1     = w_strb_ff[1];
   assign wr_flag   = do_write && addr_hit(aw_addr_ff, OFF_IRQ_FLAG);
   assign wr_mask   = do_write && addr_hit(aw_addr_ff, OFF_IRQ_MASK);
   assign wr_trig   = do_write && addr_hit(aw_addr_ff, OFF_START_TRIG);
   assign wr_data   = do_write && addr_hit(aw_addr_ff, OFF_DATA);
   assign wr_alias  = do_write && addr_hit(aw_addr_ff, OFF_ALIAS);   // [RL9]
   assign wr_errclr = do_write && addr_hit(aw_addr_ff, OFF_ERR_CLEAR);
   assign wr_mapped = wr_flag || wr_mask || wr_trig || wr_data || wr_alias || wr_errclr
                      || addr_hit(aw_addr_ff, OFF_STATUS) || addr_hit(aw_addr_ff, OFF_ENABLE);

   // A byte written to the low half or the alias while enabled becomes the next transfer
   assign load_byte = (wr_data || wr_alias) && lane0 && enable_ff;   // [RL8]

   // Engine pulls the waiting byte as soon as it is idle
   assign sh_start  = buf_full_ff && !sh_busy;   // [RL8]

   // Byte buffer: a new byte wins over the engine taking the old one
   assign nxt_buf_full = load_byte ? 1'b1 : (sh_start ? 1'b0 : buf_full_ff);

   // Overrun: byte written while a previous one still waits
   assign nxt_overrun  = (load_byte && buf_full_ff && !sh_start) ? 1'b1 :
                         ((wr_errclr && lane0 && w_data_ff[OVERRUN_BIT]) ? 1'b0 : overrun_ff);

   // Request flag: transfer end sets, write of one clears, set wins
   assign nxt_flag = sh_done ? 1'b1 :                                     // [RL11]
                     ((wr_flag && lane0 && w_data_ff[XFER_END_BIT]) ? 1'b0 : flag_ff);  // [RL1]

   // Interrupt flag, mask and start trigger
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         flag_ff   <= FLAG_RESET;
         mask_ff   <= MASK_RESET;
         enable_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;   // [RL1]
         if (wr_mask && lane0) begin
            mask_ff <= w_data_ff[XFER_END_BIT];   // [RL2]
         end
         if (wr_trig && lane0 && w_data_ff[START_BIT]) begin
            enable_ff <= 1'b1;   // [RL4]
         end
      end
   end

   // Data register fields, buffer and overrun
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         div_ff      <= DIV_RESET;
         tx_ff       <= BYTE_RESET;
         buf_full_ff <= 1'b0;
         overrun_ff  <= 1'b0;
      end else begin
         if (wr_data && lane1) begin
            div_ff <= w_data_ff[DIV_LSB +: DIV_W];   // [RL10]
         end
         if ((wr_data || wr_alias) && lane0) begin
            tx_ff <= w_data_ff[BYTE_W-1:0];   // [RL8]
         end
         buf_full_ff <= nxt_buf_full;
         overrun_ff  <= nxt_overrun;   // [RL7]
      end
   end

   // Received byte is kept for reading through the data register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_ff <= BYTE_RESET;
      end else if (sh_done) begin
         rx_ff <= sh_rx;
      end
   end

   // Level interrupt while the unmasked request is pending
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_flag && !mask_ff;   // [RL2]
      end
   end

   assign irq = irq_ff;

   // Status: in-progress holds across back-to-back bytes
   assign status_word = {9'h000,
                         sh_busy || buf_full_ff,   // [RL6] [RL11]
                         buf_full_ff,              // [RL7]
                         2'b00,
                         1'b0,                     // Framing error never occurs here
                         1'b0,                     // Parity error never occurs here
                         overrun_ff};              // [RL7]

   assign data_word = {div_ff, 1'b0, rx_ff};

   // Read selection
   assign rd_mapped = addr_hit(s_axi_araddr, OFF_IRQ_FLAG)
                      || addr_hit(s_axi_araddr, OFF_IRQ_MASK)
                      || addr_hit(s_axi_araddr, OFF_START_TRIG)
                      || addr_hit(s_axi_araddr, OFF_STATUS)
                      || addr_hit(s_axi_araddr, OFF_DATA)
                      || addr_hit(s_axi_araddr, OFF_ALIAS)
                      || addr_hit(s_axi_araddr, OFF_ENABLE)
                      || addr_hit(s_axi_araddr, OFF_ERR_CLEAR);

   assign rd_mux =
      addr_hit(s_axi_araddr, OFF_IRQ_FLAG) ? 32'(flag_ff) << XFER_END_BIT :   // [RL1]
      addr_hit(s_axi_araddr, OFF_IRQ_MASK) ? 32'(mask_ff) << XFER_END_BIT :   // [RL2]
      addr_hit(s_axi_araddr, OFF_STATUS)   ? {16'h0000, status_word} :       // [RL7]
      addr_hit(s_axi_araddr, OFF_DATA)     ? {16'h0000, data_word} :
      addr_hit(s_axi_araddr, OFF_ALIAS)    ? {24'h00_0000, rx_ff} :          // [RL9]
      addr_hit(s_axi_araddr, OFF_ENABLE)   ? 32'(enable_ff) << ENABLE_BIT :
      32'h0000_0000;                          // Start trigger reads zero [RL5]

   // Read data register, held until taken
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         rdata_ff  <= rd_mux;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp  = rresp_ff;
   assign s_axi_rdata  = rdata_ff;

   // Serial data in crosses into the core clock domain
   ccs_sync #(
      .WIDTH (1)
   ) u_si_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in (si_in),
      .sync_out (si_sync)
   );

   // Shift engine, clock divided per the data register field
   ccs_shifter #(
      .XFER_BITS (XFER_BITS)
   ) u_shifter (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .start    (sh_start),
      .tx_byte  (tx_ff),
      .div_sel  (div_ff),     // [RL10]
      .busy     (sh_busy),
      .done     (sh_done),    // [RL11]
      .rx_byte  (sh_rx),
      .si_sync  (si_sync),
      .sck_out  (sck_out),
      .so_out   (so_out)
   );

endmodule // ccs_top

// [verification/ccs_top_asserts.sv]
// Concurrent checks on the channel block's ports
`timescale 1ns/1ns
module ccs_top_checker
   import ccs_pkg::*;
#(
   parameter int unsigned XFER_BITS = 8
) (
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  reset_n,
   // Bus handshakes
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   // Interrupt and serial lines
   input wire logic                  irq,
   input wire logic                  sck_out,
   input wire logic                  so_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // Outputs idle out of reset
   a_reset_idle: assert property ($rose(reset_n) |-> sck_out && so_out && !irq)
      else $error("outputs not idle after reset");
   // Data holds through the low half for the peer
   a_so_steady: assert property (!sck_out && !$fell(sck_out) |-> $stable(so_out))
      else $error("data moved in the low half");
   // Low half within the slowest divider
   a_low_bound: assert property ($fell(sck_out) |-> ##[1:128] $rose(sck_out))
      else $error("low half too long");
   // Interrupt rises only with the clock parked high
   a_irq_end: assert property ($rose(irq) |-> sck_out)
      else $error("interrupt rose mid frame");
   // Write answer two cycles after both are taken
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not on time");
   // Read data the cycle after the address is taken
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not on time");
   // Responses stand until taken
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // No new request is taken while a response waits
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response waits");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready while data waits");
endmodule // ccs_top_checker

bind ccs_top ccs_top_checker #(.XFER_BITS(XFER_BITS)) u_chk (.*);

// [verification/ccs_peer.sv]
// Serial peer model: returns its own byte and captures the device's byte
`timescale 1ns/1ns
module ccs_peer (
   // Reset from the bench
   input  wire logic       reset_n,
   // Serial lines
   input  wire logic       sck_out,
   input  wire logic       so_out,
   output      logic       si_in,
   // Bench side
   input  wire logic [7:0] tx_byte,
   output      logic [7:0] rx_byte
);
   logic [7:0] tx_sh;
   int         bit_cnt = 0;

   initial begin
      si_in = 1'b1;
      rx_byte = 8'h00;
   end
   // Next bit goes out on each falling clock, MSB first
   always @(negedge sck_out) begin
      if (bit_cnt == 0)
         tx_sh = tx_byte;
      si_in <= tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
   end
   // Capture on each rise; after the last bit the line inverts
   always @(posedge sck_out) begin
      if (!reset_n) begin
         bit_cnt = 0;
      end else begin
         rx_byte <= {rx_byte[6:0], so_out};
         bit_cnt = (bit_cnt + 1) % 8;
         if (bit_cnt == 0)
            si_in <= ~si_in;
      end
   end
endmodule // ccs_peer

// [verification/ccs_top_tb_top.sv]
// Self-checking bench for the serial channel block
`timescale 1ns/1ns
module ccs_top_tb_top
   import ccs_pkg::*;
();
   logic        core_clk, reset_n, irq, sck_out, so_out, si_in;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, peer_tx, peer_rx;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   int          error_cnt = 0, checks = 0;

   // Device under test and its serial peer
   ccs_top #(.XFER_BITS(8)) DUT (.*);
   ccs_peer PEER (.reset_n(reset_n), .sck_out(sck_out), .so_out(so_out), .si_in(si_in),
      .tx_byte(peer_tx), .rx_byte(peer_rx));

   // Core clock, 100 ns period
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write: each channel held until taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge core_clk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end while (tb !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   // Bus read: address held until taken
   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk);
         if (ta)
            s_axi_arvalid <= 1'b0;
      end while (tr !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(rd, e);
   endtask

   task automatic irq_is(input logic e);
      @(negedge core_clk);
      chk(32'(irq), 32'(e));
   endtask

   // Poll the in-progress bit until the channel goes quiet
   task automatic wait_idle();
      do axr(OFF_STATUS); while (rd[IN_PROGRESS_BIT] !== 1'b0);
   endtask

   task automatic t_reset();
      rc(OFF_IRQ_FLAG, 32'h0000_0000);
      rc(OFF_IRQ_MASK, 32'h0000_0020);
      rc(OFF_STATUS, 32'h0000_0000);
      $display("test reset finished");
   endtask

   // Trigger: zero does nothing, one enables, reads zero
   task automatic t_start();
      axw(OFF_START_TRIG, 32'h0000_0000, 4'hF);
      rc(OFF_ENABLE, 32'h0000_0000);
      axw(OFF_DATA, 32'h0000_0611, 4'h3);
      rc(OFF_STATUS, 32'h0000_0000);
      axw(OFF_START_TRIG, 32'h0000_FFFF, 4'hF);
      rc(OFF_ENABLE, 32'h0000_0001);
      rc(OFF_START_TRIG, 32'h0000_0000);
      rc(OFF_STATUS, 32'h0000_0000);
      $display("test start finished");
   endtask

   // One byte each way, divider 3, so 4 cycles a half
   task automatic t_xfer();
      int n;
      peer_tx = 8'h3C;
      axw(OFF_DATA, 32'h0000_06A5, 4'h3);
      do @(negedge core_clk); while (sck_out !== 1'b0);
      for (n = 0; sck_out === 1'b0; n++)
         @(negedge core_clk);
      chk(n, 32'd4);
      rc(OFF_STATUS, 32'h0000_0040);
      wait_idle();
      rc(OFF_STATUS, 32'h0000_0000);
      rc(OFF_IRQ_FLAG, 32'h0000_0020);
      irq_is(1'b0);
      chk(32'(peer_rx), 32'h0000_00A5);
      rc(OFF_ALIAS, 32'h0000_003C);
      $display("test transfer finished");
   endtask

   // Interrupt follows flag and mask; transfer through the alias
   task automatic t_irq();
      axw(OFF_IRQ_FLAG, 32'h0000_0020, 4'h1);
      rc(OFF_IRQ_FLAG, 32'h0000_0000);
      axw(OFF_IRQ_MASK, 32'h0000_0000, 4'h1);
      irq_is(1'b0);
      peer_tx = 8'hC3;
      axw(OFF_ALIAS, 32'h0000_005A, 4'h1);
      while (irq !== 1'b1)
         @(negedge core_clk);
      irq_is(1'b1);
      chk(32'(peer_rx), 32'h0000_005A);
      rc(OFF_ALIAS, 32'h0000_00C3);
      axw(OFF_IRQ_MASK, 32'h0000_0020, 4'h1);
      irq_is(1'b0);
      axw(OFF_IRQ_MASK, 32'h0000_0000, 4'h1);
      irq_is(1'b1);
      axw(OFF_IRQ_FLAG, 32'h0000_0020, 4'h1);
      irq_is(1'b0);
      axw(OFF_IRQ_MASK, 32'h0000_0020, 4'h1);
      $display("test interrupt finished");
   endtask

   // Back-to-back bytes; the third write overruns and replaces the waiting one
   task automatic t_over();
      peer_tx = 8'h0F;
      axw(OFF_DATA, 32'h0000_0611, 4'h3);
      axw(OFF_ALIAS, 32'h0000_0022, 4'h1);
      axw(OFF_ALIAS, 32'h0000_0033, 4'h1);
      rc(OFF_STATUS, 32'h0000_0061);
      wait_idle();
      chk(32'(peer_rx), 32'h0000_0033);
      rc(OFF_STATUS, 32'h0000_0001);
      axw(OFF_ERR_CLEAR, 32'h0000_0001, 4'h1);
      rc(OFF_STATUS, 32'h0000_0000);
      axw(8'h40, 32'h0000_0000, 4'hF);
      chk(32'(rs), 32'(RESP_SLVERR));
      axr(8'h40);
      chk(32'(rs), 32'(RESP_SLVERR));
      rc(OFF_IRQ_MASK, 32'h0000_0020);
      $display("test overrun and unmapped finished");
   endtask

   // Reset, then the tests in turn
   initial begin
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      peer_tx = 8'h00;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset();
      t_start();
      t_xfer();
      t_irq();
      t_over();
      conclude();
   end

   // Watchdog; the tests need well under 2000 cycles
   initial begin
      #500_000;
      error_cnt++;
      conclude();
   end
endmodule // ccs_top_tb_top
